// >>> verilog/ata_cmd_map.svh
// opcodes, identify word addresses, values and sizes of the command decoder
`ifndef ATA_CMD_MAP_SVH
`define ATA_CMD_MAP_SVH

// opcodes
`define OP_RD_SEC0 8'h20
`define OP_RD_SEC1 8'h21
`define OP_RD_MULT 8'hC4
`define OP_RD_VFY0 8'h40
`define OP_RD_VFY1 8'h41
`define OP_WR_SEC0 8'h30
`define OP_WR_SEC1 8'h31
`define OP_WR_MULT 8'hC5
`define OP_WR_VFY 8'h3C
`define OP_WR_NOER 8'h38
`define OP_WM_NOER 8'hCD
`define OP_RD_DMA0 8'hC8
`define OP_RD_DMA1 8'hC9
`define OP_WR_DMA0 8'hCA
`define OP_WR_DMA1 8'hCB
`define OP_CHK_PWR0 8'hE5
`define OP_CHK_PWR1 8'h98
`define OP_SLEEP0 8'hE6
`define OP_SLEEP1 8'h99
`define OP_IDLE0 8'hE3
`define OP_IDLE1 8'h97
`define OP_IDLE_IM0 8'hE1
`define OP_IDLE_IM1 8'h95
`define OP_STBY0 8'hE2
`define OP_STBY1 8'h96
`define OP_STBY_IM0 8'hE0
`define OP_STBY_IM1 8'h94
`define OP_SET_MULT 8'hC6
`define OP_IDENTIFY 8'hEC
`define OP_SET_FEAT 8'hEF
`define OP_DIAG 8'h90
`define OP_ERASE 8'hC0
`define OP_FORMAT 8'h50

// set features: select multiword dma mode
`define FEAT_XFER_MODE 8'h03
`define XFER_MDMA_TAG 5'h04

// identify block
`define ID_LAST 8'hFF
`define W_GENCFG 8'h00
`define W_CYL 8'h01
`define W_HEADS 8'h03
`define W_SPT 8'h06
`define W_CAP_MSW 8'h07
`define W_CAP_LSW 8'h08
`define W_SER_LO 8'h0A
`define W_SER_HI 8'h13
`define W_ECC 8'h16
`define W_FW_LO 8'h17
`define W_FW_HI 8'h1A
`define W_MOD_LO 8'h1B
`define W_MOD_HI 8'h2E
`define W_MAXMULT 8'h2F
`define W_CAPAB 8'h31
`define W_PIO 8'h33
`define W_VALID 8'h35
`define W_CUR_CYL 8'h36
`define W_CUR_HEADS 8'h37
`define W_CUR_SPT 8'h38
`define W_CUR_LSW 8'h39
`define W_CUR_MSW 8'h3A
`define W_MULT_SET 8'h3B
`define W_LBA_LSW 8'h3C
`define W_LBA_MSW 8'h3D
`define W_MDMA 8'h3F
`define W_ADV_PIO 8'h40
`define W_MDMA_MIN 8'h41
`define W_MDMA_REC 8'h42
`define W_PIO_MIN 8'h43
`define W_PIO_IORDY 8'h44
`define W_MAJOR 8'h50
`define W_FEAT83 8'h53
`define W_FEAT84 8'h54
`define W_FEAT86 8'h56
`define W_FEAT87 8'h57

`define V_GENCFG 16'h848A
`define V_ECC 16'h0004
`define V_MAXMULT 16'h0001
`define V_CAP_DMA 16'h0300
`define V_CAP_NODMA 16'h0100
`define V_PIO 16'h0200
`define V_VALID 16'h0003
`define V_MULT_VLD 8'h01
`define V_MDMA_SUP 8'h07
`define V_ADV_PIO 16'h0003
`define V_CYC 16'h0078
`define V_FEAT83 16'h4004
`define V_FEAT84 16'h4000
`define V_FEAT86 16'h0004
`define V_FEAT87 16'h4000
`define V_ZERO 16'h0000

`define FIFO_DEPTH 32
`define FIFO_AW 5

`endif

// >>> verilog/ata_cmd_pkg.sv
// types shared by the command decoder
`default_nettype none
package ata_cmd_pkg;
    typedef enum logic [4:0] {
        CMD_NONE = 5'h00, CMD_RD_SEC = 5'h01, CMD_RD_MULT = 5'h02,
        CMD_RD_VFY = 5'h03, CMD_WR_SEC = 5'h04, CMD_WR_MULT = 5'h05,
        CMD_WR_VFY = 5'h06, CMD_WR_NOER = 5'h07, CMD_WM_NOER = 5'h08,
        CMD_RD_DMA = 5'h09, CMD_WR_DMA = 5'h0A, CMD_CHK_PWR = 5'h0B,
        CMD_SLEEP = 5'h0C, CMD_IDLE = 5'h0D, CMD_IDLE_IM = 5'h0E,
        CMD_STBY = 5'h0F, CMD_STBY_IM = 5'h10, CMD_SET_MULT = 5'h11,
        CMD_IDENTIFY = 5'h12, CMD_SET_FEAT = 5'h13, CMD_DIAG = 5'h14,
        CMD_ERASE = 5'h15, CMD_FORMAT = 5'h16
    } cmd_t;
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00, PWR_IDLE = 2'b01, PWR_STBY = 2'b10,
        PWR_SLEEP = 2'b11
    } pwr_t;
    typedef enum logic [0:0] {
        ST_READY = 1'b0, ST_IDENT = 1'b1
    } state_t;
endpackage
`default_nettype wire

// >>> verilog/ata_cmd_decode.sv
// command decoder with identify-data generator and its output fifo
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_map.svh"

// ----------------------------------------
// fifo with registered output stage
// ----------------------------------------
module ata_id_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire full = (count == (AW+1)'(DEPTH));
    wire empty = (count == '0);
    wire push = in_valid && !full;
    wire load = !empty && (!out_valid || out_ready);
    assign in_ready = !full;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(load);
        end
    end
endmodule

// ----------------------------------------
// top: command decode and identify
// ----------------------------------------
module ata_cmd_decode
    import ata_cmd_pkg::*;
#(
    parameter logic [159:0] SERIAL = "          0000000001",
    parameter logic [63:0] FW_REV = "REV 1.00",
    parameter logic [319:0] MODEL =
        "FLASH CARD                              ",
    parameter logic [15:0] MAJOR_VER = 16'h0000
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // command register write and task-file inputs
    input wire logic I_CMD_WR,
    input wire logic [7:0] I_CMD,
    input wire logic [7:0] I_FEATURE,
    input wire logic [7:0] I_SECTOR_COUNT,
    // card configuration
    input wire logic I_IDE_MODE,
    input wire logic I_MDMA_SUPPORTED,
    input wire logic [31:0] I_TOTAL_SECTORS,
    input wire logic [15:0] I_CYLINDERS,
    input wire logic [15:0] I_HEADS,
    input wire logic [15:0] I_SECTORS_PER_TRACK,
    // decoded command
    output logic O_CMD_STB,
    output cmd_t O_CMD,
    output logic O_ABORT,
    output logic O_BUSY,
    output pwr_t O_POWER_STATE,
    output logic [7:0] O_MULT_COUNT,
    output logic [7:0] O_MDMA_ACTIVE,
    // identify data stream
    output logic O_ID_VALID,
    output logic [15:0] O_ID_DATA,
    input wire logic I_ID_READY
);
    state_t state;
    state_t next_state;
    logic [7:0] word_addr;
    logic [7:0] mult_count;
    logic [7:0] mdma_active;
    pwr_t pwr;
    logic [15:0] id_word;

    // ----------------------------------------
    // opcode decode
    // ----------------------------------------
    function automatic logic [5:0] decode_op(input logic [7:0] op);
        // bit 5 is the supported flag, low bits the command code
        case (op)
            `OP_RD_SEC0, `OP_RD_SEC1: decode_op = {1'b1, CMD_RD_SEC};
            `OP_RD_MULT: decode_op = {1'b1, CMD_RD_MULT};
            `OP_RD_VFY0, `OP_RD_VFY1: decode_op = {1'b1, CMD_RD_VFY};
            `OP_WR_SEC0, `OP_WR_SEC1: decode_op = {1'b1, CMD_WR_SEC};
            `OP_WR_MULT: decode_op = {1'b1, CMD_WR_MULT};
            `OP_WR_VFY: decode_op = {1'b1, CMD_WR_VFY};
            `OP_WR_NOER: decode_op = {1'b1, CMD_WR_NOER};
            `OP_WM_NOER: decode_op = {1'b1, CMD_WM_NOER};
            `OP_RD_DMA0, `OP_RD_DMA1: decode_op = {1'b1, CMD_RD_DMA};
            `OP_WR_DMA0, `OP_WR_DMA1: decode_op = {1'b1, CMD_WR_DMA};
            `OP_CHK_PWR0, `OP_CHK_PWR1: decode_op = {1'b1, CMD_CHK_PWR};
            `OP_SLEEP0, `OP_SLEEP1: decode_op = {1'b1, CMD_SLEEP};
            `OP_IDLE0, `OP_IDLE1: decode_op = {1'b1, CMD_IDLE};
            `OP_IDLE_IM0, `OP_IDLE_IM1: decode_op = {1'b1, CMD_IDLE_IM};
            `OP_STBY0, `OP_STBY1: decode_op = {1'b1, CMD_STBY};
            `OP_STBY_IM0, `OP_STBY_IM1: decode_op = {1'b1, CMD_STBY_IM};
            `OP_SET_MULT: decode_op = {1'b1, CMD_SET_MULT};
            `OP_IDENTIFY: decode_op = {1'b1, CMD_IDENTIFY};
            `OP_SET_FEAT: decode_op = {1'b1, CMD_SET_FEAT};
            `OP_DIAG: decode_op = {1'b1, CMD_DIAG};
            `OP_ERASE: decode_op = {1'b1, CMD_ERASE};
            `OP_FORMAT: decode_op = {1'b1, CMD_FORMAT};
            default: decode_op = {1'b0, CMD_NONE};
        endcase
    endfunction

    wire [5:0] dec = decode_op(I_CMD);
    wire dec_ok = dec[5];
    wire cmd_t dec_cmd = cmd_t'(dec[4:0]);
    wire take = I_CMD_WR && (state == ST_READY);
    wire accept = take && dec_ok;
    wire reject = take && !dec_ok;
    wire start_id = accept && (dec_cmd == CMD_IDENTIFY);
    wire mdma_sel = (I_FEATURE == `FEAT_XFER_MODE) &&
        (I_SECTOR_COUNT[7:3] == `XFER_MDMA_TAG);
    wire dma_ide = I_MDMA_SUPPORTED && I_IDE_MODE;

    // ----------------------------------------
    // identify word map
    // ----------------------------------------
    function automatic logic [15:0] str_word(input logic [319:0] s,
                                             input int nwords,
                                             input int idx);
        // first character lands in the high byte of each word
        str_word = s[(nwords - idx) * 16 - 1 -: 16];
    endfunction

    // unlisted words fall through to zero
    always_comb begin
        id_word = `V_ZERO;
        case (word_addr)
            `W_GENCFG: id_word = `V_GENCFG;
            `W_CYL, `W_CUR_CYL: id_word = I_CYLINDERS;
            `W_HEADS, `W_CUR_HEADS: id_word = I_HEADS;
            `W_SPT, `W_CUR_SPT: id_word = I_SECTORS_PER_TRACK;
            `W_CAP_MSW: id_word = I_TOTAL_SECTORS[31:16];
            `W_CAP_LSW: id_word = I_TOTAL_SECTORS[15:0];
            `W_ECC: id_word = `V_ECC;
            `W_MAXMULT: id_word = `V_MAXMULT;
            `W_CAPAB: id_word = I_MDMA_SUPPORTED ? `V_CAP_DMA
                                                 : `V_CAP_NODMA;
            `W_PIO: id_word = `V_PIO;
            `W_VALID: id_word = `V_VALID;
            `W_CUR_LSW: id_word = I_TOTAL_SECTORS[15:0];
            `W_CUR_MSW: id_word = I_TOTAL_SECTORS[31:16];
            `W_MULT_SET: id_word = {`V_MULT_VLD, mult_count};
            `W_LBA_LSW: id_word = I_TOTAL_SECTORS[15:0];
            `W_LBA_MSW: id_word = I_TOTAL_SECTORS[31:16];
            `W_MDMA: id_word = I_MDMA_SUPPORTED ?
                {mdma_active, `V_MDMA_SUP} : `V_ZERO;
            `W_ADV_PIO: id_word = `V_ADV_PIO;
            `W_MDMA_MIN, `W_MDMA_REC:
                id_word = dma_ide ? `V_CYC : `V_ZERO;
            `W_PIO_MIN, `W_PIO_IORDY: id_word = `V_CYC;
            `W_FEAT83: id_word = `V_FEAT83;
            `W_FEAT84: id_word = `V_FEAT84;
            `W_FEAT86: id_word = `V_FEAT86;
            `W_FEAT87: id_word = `V_FEAT87;
            `W_MAJOR: id_word = MAJOR_VER;
            default: begin
                if (word_addr >= `W_SER_LO && word_addr <= `W_SER_HI) begin
                    id_word = str_word({160'h0, SERIAL}, 10,
                        int'(word_addr - `W_SER_LO));
                end else if (word_addr >= `W_FW_LO &&
                             word_addr <= `W_FW_HI) begin
                    id_word = str_word({256'h0, FW_REV}, 4,
                        int'(word_addr - `W_FW_LO));
                end else if (word_addr >= `W_MOD_LO &&
                             word_addr <= `W_MOD_HI) begin
                    id_word = str_word(MODEL, 20,
                        int'(word_addr - `W_MOD_LO));
                end
            end
        endcase
    end

    // ----------------------------------------
    // identify streaming into the fifo
    // ----------------------------------------
    wire fifo_ready;
    wire push = (state == ST_IDENT);
    wire push_done = push && fifo_ready;
    wire last_word = push_done && (word_addr == `ID_LAST);

    always_comb begin
        next_state = state;
        case (state)
            ST_READY: begin
                if (start_id) begin
                    next_state = ST_IDENT;
                end
            end
            ST_IDENT: begin
                if (last_word) begin
                    next_state = ST_READY;
                end
            end
            default: next_state = ST_READY;
        endcase
    end

    ata_id_fifo #(
        .WIDTH(16),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk(I_CLK),
        .rst_n(I_RESETN),
        .in_valid(push),
        .in_data(id_word),
        .in_ready(fifo_ready),
        .out_valid(O_ID_VALID),
        .out_data(O_ID_DATA),
        .out_ready(I_ID_READY)
    );

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state <= ST_READY;
            word_addr <= 8'h00;
        end else begin
            state <= next_state;
            if (start_id) begin
                word_addr <= 8'h00;
            end else if (push_done) begin
                word_addr <= word_addr + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // command outputs and card state
    // ----------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_CMD_STB <= 1'b0;
            O_CMD <= CMD_NONE;
            O_ABORT <= 1'b0;
            O_BUSY <= 1'b0;
        end else begin
            O_CMD_STB <= accept;
            O_ABORT <= reject;
            if (take) begin
                O_CMD <= dec_cmd;
            end
            O_BUSY <= (next_state == ST_IDENT);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pwr <= PWR_ACTIVE;
            mult_count <= 8'h00;
            mdma_active <= 8'h00;
        end else if (accept) begin
            case (dec_cmd)
                CMD_SLEEP: pwr <= PWR_SLEEP;
                CMD_IDLE, CMD_IDLE_IM: pwr <= PWR_IDLE;
                CMD_STBY, CMD_STBY_IM: pwr <= PWR_STBY;
                CMD_SET_MULT: begin
                    mult_count <= I_SECTOR_COUNT;
                    pwr <= PWR_ACTIVE;
                end
                CMD_SET_FEAT: begin
                    if (mdma_sel && I_MDMA_SUPPORTED) begin
                        mdma_active <= 8'h01 << I_SECTOR_COUNT[2:0];
                    end
                    pwr <= PWR_ACTIVE;
                end
                CMD_CHK_PWR: pwr <= pwr;
                default: pwr <= PWR_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_POWER_STATE <= PWR_ACTIVE;
            O_MULT_COUNT <= 8'h00;
            O_MDMA_ACTIVE <= 8'h00;
        end else begin
            O_POWER_STATE <= pwr;
            O_MULT_COUNT <= mult_count;
            O_MDMA_ACTIVE <= mdma_active;
        end
    end
endmodule
`default_nettype wire

// >>> test/ata_cmd_monitor.sv
// assertion checker watching the command decoder ports
`timescale 1ns/1ps
`default_nettype none
module ata_cmd_monitor
    import ata_cmd_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // command side
    input wire logic I_CMD_WR,
    input wire logic [7:0] I_CMD,
    input wire logic [7:0] I_SECTOR_COUNT,
    input wire logic O_CMD_STB,
    input wire cmd_t O_CMD,
    input wire logic O_ABORT,
    input wire logic O_BUSY,
    input wire pwr_t O_POWER_STATE,
    input wire logic [7:0] O_MULT_COUNT,
    // identify stream
    input wire logic O_ID_VALID,
    input wire logic [15:0] O_ID_DATA,
    input wire logic I_ID_READY
);
    // ----------------------------------------
    // word index of the stream head
    // ----------------------------------------
    logic [7:0] idx;
    wire take = I_CMD_WR && !O_BUSY;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN)
            idx <= 8'h00;
        else if (O_ID_VALID && I_ID_READY)
            idx <= idx + 8'h01;
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_one_answer: assert property (
        take |=> O_CMD_STB != O_ABORT)
        else $error("command not answered by exactly one pulse");
    chk_answer_cause: assert property (
        (O_CMD_STB || O_ABORT) |-> $past(take))
        else $error("answer pulse without a taken command");
    chk_busy_ignore: assert property (
        I_CMD_WR && O_BUSY |=> !O_CMD_STB && !O_ABORT)
        else $error("command taken while identify runs");
    chk_abort_code: assert property (
        O_ABORT |-> O_CMD == CMD_NONE)
        else $error("rejected opcode left a command code");
    chk_ident_start: assert property (
        take && I_CMD == 8'hEC |=> O_CMD == CMD_IDENTIFY && O_BUSY)
        else $error("identify not started");
    chk_sleep_state: assert property (
        take && (I_CMD == 8'hE6 || I_CMD == 8'h99) ##1 !I_CMD_WR [*2]
        |=> O_POWER_STATE == PWR_SLEEP)
        else $error("sleep not entered");
    chk_mult_value: assert property (
        take && I_CMD == 8'hC6 ##1 !I_CMD_WR [*2]
        |=> O_MULT_COUNT == $past(I_SECTOR_COUNT, 3))
        else $error("block count not stored");
    chk_word_hold: assert property (
        O_ID_VALID && !I_ID_READY |=> O_ID_VALID && $stable(O_ID_DATA))
        else $error("identify word dropped while stalled");
    chk_gen_config: assert property (
        O_ID_VALID && idx == 8'h00 |-> O_ID_DATA == 16'h848A)
        else $error("word 0 wrong");
    chk_ecc_count: assert property (
        O_ID_VALID && idx == 8'h16 |-> O_ID_DATA == 16'h0004)
        else $error("word 22 wrong");
    chk_field_valid: assert property (
        O_ID_VALID && idx == 8'h35 |-> O_ID_DATA == 16'h0003)
        else $error("word 53 wrong");
    chk_pio_cycle: assert property (
        O_ID_VALID && (idx == 8'h43 || idx == 8'h44)
        |-> O_ID_DATA == 16'h0078)
        else $error("pio cycle time word wrong");
    chk_reserved_zero: assert property (
        O_ID_VALID && idx >= 8'hB0 |-> O_ID_DATA == 16'h0000)
        else $error("reserved word not zero");
    cover property (take && I_CMD == 8'hEC);
    cover property (O_ABORT);
    cover property (O_ID_VALID && !I_ID_READY [*4]);
endmodule
`default_nettype wire

// >>> test/ata_id_host.sv
// identify stream consumer standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module ata_id_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // stall request from the bench
    input wire logic stall,
    // stream
    input wire logic valid,
    input wire logic [15:0] data,
    output logic ready,
    output logic [9:0] count
);
    logic [15:0] words [0:255];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
            count <= 10'h000;
        end else begin
            ready <= !stall;
            if (valid && ready) begin
                words[count[7:0]] <= data;
                count <= count + 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/tb_ata_command_decode_identify.sv
// self-checking bench for the command decoder and identify stream
`timescale 1ns/1ps
`default_nettype none
module tb_ata_command_decode_identify
    import ata_cmd_pkg::*;
;
    localparam logic [159:0] SER = "        CARD00004321";
    localparam logic [63:0] FWR = "FW  2.10";
    localparam logic [319:0] MDL = "MODEL-0123456789-ABCDEFGHIJKLMNOPQRSTUVW";
    logic clk = 1'b0;
    logic rst_n, wr, ide, sup, stall, ready, stb, abort, busy, vld;
    logic [7:0] op, feat, cnt, mcount, mact, mult, mdma;
    logic [15:0] cyl, hds, spt, data;
    logic [31:0] tot, seed = 32'h0000A0A0;
    logic [9:0] hcnt;
    cmd_t code;
    pwr_t pstate, pwr;
    int errors = 0;
    int n_checks = 0;
    logic [7:0] ops [$] = '{8'h20, 8'h21, 8'hC4, 8'h40, 8'h41, 8'h30,
        8'h31, 8'hC5, 8'h3C, 8'h38, 8'hCD, 8'hC8, 8'hC9, 8'hCA, 8'hCB,
        8'hE5, 8'hE6, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'hE2, 8'h96,
        8'hE0, 8'h94, 8'h99, 8'hC6, 8'hEF, 8'h90, 8'hC0, 8'h50, 8'h91,
        8'hE4, 8'h10, 8'h1F, 8'h03, 8'h70, 8'h7F, 8'h87, 8'hF5, 8'hE8};
    always #5 clk = ~clk;
    ata_cmd_decode #(.SERIAL(SER), .FW_REV(FWR), .MODEL(MDL)) dut (
        .I_CLK(clk), .I_RESETN(rst_n), .I_CMD_WR(wr), .I_CMD(op),
        .I_FEATURE(feat), .I_SECTOR_COUNT(cnt), .I_IDE_MODE(ide),
        .I_MDMA_SUPPORTED(sup), .I_TOTAL_SECTORS(tot), .I_CYLINDERS(cyl),
        .I_HEADS(hds), .I_SECTORS_PER_TRACK(spt), .O_CMD_STB(stb),
        .O_CMD(code), .O_ABORT(abort), .O_BUSY(busy),
        .O_POWER_STATE(pstate), .O_MULT_COUNT(mcount),
        .O_MDMA_ACTIVE(mact), .O_ID_VALID(vld), .O_ID_DATA(data),
        .I_ID_READY(ready));
    ata_id_host host (.clk(clk), .rst_n(rst_n), .stall(stall),
        .valid(vld), .data(data), .ready(ready), .count(hcnt));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic cmd_t exp_cmd(input logic [7:0] o);
        case (o)
        8'h20, 8'h21: return CMD_RD_SEC;
        8'hC4: return CMD_RD_MULT;
        8'h40, 8'h41: return CMD_RD_VFY;
        8'h30, 8'h31: return CMD_WR_SEC;
        8'hC5: return CMD_WR_MULT;
        8'h3C: return CMD_WR_VFY;
        8'h38: return CMD_WR_NOER;
        8'hCD: return CMD_WM_NOER;
        8'hC8, 8'hC9: return CMD_RD_DMA;
        8'hCA, 8'hCB: return CMD_WR_DMA;
        8'hE5, 8'h98: return CMD_CHK_PWR;
        8'hE6, 8'h99: return CMD_SLEEP;
        8'hE3, 8'h97: return CMD_IDLE;
        8'hE1, 8'h95: return CMD_IDLE_IM;
        8'hE2, 8'h96: return CMD_STBY;
        8'hE0, 8'h94: return CMD_STBY_IM;
        8'hC6: return CMD_SET_MULT;
        8'hEF: return CMD_SET_FEAT;
        8'h90: return CMD_DIAG;
        8'hC0: return CMD_ERASE;
        8'h50: return CMD_FORMAT;
        default: return CMD_NONE;
        endcase
    endfunction
    function automatic pwr_t exp_pwr(input cmd_t c, input pwr_t p);
        case (c)
        CMD_SLEEP: return PWR_SLEEP;
        CMD_IDLE, CMD_IDLE_IM: return PWR_IDLE;
        CMD_STBY, CMD_STBY_IM: return PWR_STBY;
        CMD_CHK_PWR, CMD_NONE: return p;
        default: return PWR_ACTIVE;
        endcase
    endfunction
    function automatic logic [15:0] exp_word(input int i);
        if (i >= 10 && i <= 19) return SER[159-16*(i-10) -: 16];
        if (i >= 23 && i <= 26) return FWR[63-16*(i-23) -: 16];
        if (i >= 27 && i <= 46) return MDL[319-16*(i-27) -: 16];
        case (i)
        0: return 16'h848A;
        1, 54: return cyl;
        3, 55: return hds;
        6, 56: return spt;
        7, 58, 61: return tot[31:16];
        8, 57, 60: return tot[15:0];
        22: return 16'h0004;
        47: return 16'h0001;
        49: return sup ? 16'h0300 : 16'h0100;
        51: return 16'h0200;
        53, 64: return 16'h0003;
        59: return {8'h01, mult};
        63: return sup ? {mdma, 8'h07} : 16'h0000;
        65, 66: return (sup && ide) ? 16'h0078 : 16'h0000;
        67, 68: return 16'h0078;
        83: return 16'h4004;
        84, 87: return 16'h4000;
        86: return 16'h0004;
        default: return 16'h0000;
        endcase
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // drives one command write, returns after the taking edge
    task automatic send(input logic [7:0] o, input logic [7:0] f,
        input logic [7:0] c);
        wr = 1'b1;
        op = o;
        feat = f;
        cnt = c;
        step(1);
        wr = 1'b0;
        op = ~o;
        feat = ~f;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // identify run with a full fifo, then random stalls
    // ----------------------------------------
    task automatic run_id(input logic s, input logic m);
        int k;
        logic [9:0] h0;
        sup = s;
        ide = m;
        cyl = 16'(rnd() % 1024 + 1);
        hds = 16'(rnd() % 16 + 1);
        spt = 16'(rnd() % 63 + 1);
        tot = cyl * hds * spt;
        stall = 1'b1;
        send(8'hEC, 8'h00, 8'h00);
        check("identify", {code, busy}, {CMD_IDENTIFY, 1'b1});
        step(1);
        send(8'hE6, 8'h00, 8'h00);
        check("refused", {stb, abort}, 2'b00);
        step(60);
        check("full", {vld, busy, hcnt[7:0]}, {2'b11, 8'h00});
        h0 = hcnt;
        for (k = 0; k < 5000 && hcnt != h0 + 10'h100; k++) begin
            stall = rnd() % 3 == 0;
            step(1);
        end
        stall = 1'b0;
        step(3);
        check("done", {vld, busy, hcnt[7:0]}, 10'h000);
        for (k = 0; k < 256; k++)
            check($sformatf("word %0d", k), host.words[k],
                exp_word(k));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cmd_t c;
        rst_n = 1'b0;
        {wr, ide, sup, stall} = 4'h0;
        {op, feat, cnt, cyl, hds, spt, tot} = '0;
        pwr = PWR_ACTIVE;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("reset", {stb, abort, busy, vld, code, pstate}, 0);
        foreach (ops[i]) begin
            c = exp_cmd(ops[i]);
            send(ops[i], 8'(rnd()), 8'(rnd()));
            check("answer", {stb, abort},
                {c != CMD_NONE, c == CMD_NONE});
            check("code", code, c);
            step(2);
            pwr = exp_pwr(c, pwr);
            check("power", pstate, pwr);
        end
        mult = 8'(rnd());
        send(8'hC6, 8'h00, mult);
        step(2);
        check("mult", mcount, mult);
        sup = 1'b1;
        for (int m = 0; m < 3; m++) begin
            send(8'hEF, 8'h03, {5'b00100, 3'(m)});
            step(2);
            mdma = 8'h01 << m;
            check("mdma", mact, mdma);
        end
        run_id(1'b1, 1'b1);
        run_id(1'b1, 1'b0);
        run_id(1'b0, 1'b0);
        end_sim();
    end
    initial begin
        #200000;
        errors++;
        end_sim();
    end
endmodule
bind ata_cmd_decode ata_cmd_monitor mon (.I_CLK(I_CLK),
    .I_RESETN(I_RESETN), .I_CMD_WR(I_CMD_WR), .I_CMD(I_CMD),
    .I_SECTOR_COUNT(I_SECTOR_COUNT), .O_CMD_STB(O_CMD_STB), .O_CMD(O_CMD),
    .O_ABORT(O_ABORT), .O_BUSY(O_BUSY), .O_POWER_STATE(O_POWER_STATE),
    .O_MULT_COUNT(O_MULT_COUNT), .O_ID_VALID(O_ID_VALID),
    .O_ID_DATA(O_ID_DATA), .I_ID_READY(I_ID_READY));
`default_nettype wire
